// ==== core/spx_cfg.svh ====
// Offsets, field positions, reset values and rate figures of the serial port.
`ifndef SPX_CFG_SVH
`define SPX_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SPX_ADDR_CTRL 32'h0000_1028
`define SPX_ADDR_STAT 32'h0000_102C
`define SPX_ADDR_DATA 32'h0000_1030
`define SPX_ADDR_DDR 32'h0000_1034
`define SPX_ADDR_PDAT 32'h0000_1038

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define SPX_C_IRQEN 7
`define SPX_C_EN 6
`define SPX_C_ODS 5
`define SPX_C_MASTER_SELECT_BIT 4
`define SPX_C_CLOCK_IDLE_LEVEL 3
`define SPX_C_CLOCK_PHASE_SELECT 2
`define SPX_C_RATE_HI 1
`define SPX_C_RATE_LO 0
`define SPX_CTRL_RESET 8'h04

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SPX_S_DONE 7
`define SPX_S_WRITE_COLLISION_FLAG 6
`define SPX_S_MODE_FAULT_FLAG 4

// ----------------------------------------------------------------------
// Port D pin positions and reset values
// ----------------------------------------------------------------------
`define SPX_PIN_MISO 2
`define SPX_PIN_MOSI 3
`define SPX_PIN_SCK 4
`define SPX_PIN_SS 5
`define SPX_DDR_RESET 6'h00
`define SPX_PDAT_RESET 6'h00

// ----------------------------------------------------------------------
// Clock divide factors per rate code, and bits and clock edges per character
// ----------------------------------------------------------------------
`define SPX_DIV_CODE0 6'd2
`define SPX_DIV_CODE1 6'd4
`define SPX_DIV_CODE2 6'd16
`define SPX_DIV_CODE3 6'd32
`define SPX_BITS 4'd8
`define SPX_EDGES 5'd16

`endif

// ==== core/spx_pkg.sv ====
// Types shared by the serial port design.
package spx_pkg;

    typedef enum {
        SPX_REG_NONE,
        SPX_REG_CTRL,
        SPX_REG_STAT,
        SPX_REG_DATA,
        SPX_REG_DDR,
        SPX_REG_PDAT
    } spx_reg_t;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe_n;
    } spx_pad_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] ddr;
        logic [5:0] pdat;
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic transfer_done_flag_seen;
        logic write_collision_flag_seen;
        logic mode_fault_flag_seen;
        logic [7:0] shift;
        logic [7:0] rbuf;
        logic out_bit;
        logic busy;
        logic [4:0] edge_cnt;
        logic [4:0] div_cnt;
        logic sck_lvl;
        logic [3:0] bit_cnt;
        logic sck_prev;
        logic ss_prev;
        logic d_act;
        logic d_write;
        logic [31:0] d_addr;
        logic [31:0] hrdata;
        logic irq;
        spx_pad_t pad;
    } spx_state_t;

endpackage : spx_pkg

// ==== core/spx_port.sv ====
// Byte-wide serial port, master or slave, with an AHB-Lite register slave.
`timescale 1ns/1ps

module spx_port
    import spx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic irq,
    input wire logic [5:0] pad_in,
    output spx_pkg::spx_pad_t pad_o
);
    import spx_pkg::*;
    `include "spx_cfg.svh"

    spx_state_t state_reg;
    spx_state_t state_next;
    logic hready_reg;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic spx_reg_t decode(input logic [31:0] a);
        case (a)
            `SPX_ADDR_CTRL: decode = SPX_REG_CTRL;
            `SPX_ADDR_STAT: decode = SPX_REG_STAT;
            `SPX_ADDR_DATA: decode = SPX_REG_DATA;
            `SPX_ADDR_DDR: decode = SPX_REG_DDR;
            `SPX_ADDR_PDAT: decode = SPX_REG_PDAT;
            default: decode = SPX_REG_NONE;
        endcase
    endfunction : decode

    // Half a serial clock period, in bus clocks.
    function automatic logic [4:0] half_period(input logic [1:0] code);
        logic [5:0] div;
        case (code)
            2'b00: div = `SPX_DIV_CODE0;
            2'b01: div = `SPX_DIV_CODE1;
            2'b10: div = `SPX_DIV_CODE2;
            default: div = `SPX_DIV_CODE3;
        endcase
        half_period = div[5:1];
    endfunction : half_period

    // Open-drain mode releases the pin instead of driving a one.
    function automatic logic pad_oe_n(input logic drv, input logic val,
                                      input logic ods);
        pad_oe_n = !(drv && !(ods && val));
    endfunction : pad_oe_n

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic a_take;
        logic ar;
        logic dw;
        spx_reg_t rd_id;
        spx_reg_t wr_id;
        logic [7:0] wd;
        logic en;
        logic master_select_bit;
        logic clock_idle_level;
        logic clock_phase_select;
        logic ss_in;
        logic sck_in;
        logic lead;
        logic sample;
        logic data_acc;
        logic set_transfer_done_flag;
        logic set_write_collision_flag;
        logic set_mode_fault_flag;
        logic [7:0] rx;
        logic [5:0] drv;
        logic [5:0] val;
        a_take = 1'b0;
        ar = 1'b0;
        dw = 1'b0;
        rd_id = SPX_REG_NONE;
        wr_id = SPX_REG_NONE;
        wd = 8'h00;
        en = 1'b0;
        master_select_bit = 1'b0;
        clock_idle_level = 1'b0;
        clock_phase_select = 1'b0;
        ss_in = 1'b1;
        sck_in = 1'b0;
        lead = 1'b0;
        sample = 1'b0;
        data_acc = 1'b0;
        set_transfer_done_flag = 1'b0;
        set_write_collision_flag = 1'b0;
        set_mode_fault_flag = 1'b0;
        rx = 8'h00;
        drv = 6'h00;
        val = 6'h00;
        state_next = state_reg;

        en = state_reg.ctrl[`SPX_C_EN];
        master_select_bit = state_reg.ctrl[`SPX_C_MASTER_SELECT_BIT];
        clock_idle_level = state_reg.ctrl[`SPX_C_CLOCK_IDLE_LEVEL];
        clock_phase_select = state_reg.ctrl[`SPX_C_CLOCK_PHASE_SELECT];
        ss_in = pad_in[`SPX_PIN_SS];
        sck_in = pad_in[`SPX_PIN_SCK];

        // Bus: address phase is answered at once, writes land in data phase.
        a_take = hsel && htrans[1] && hready;
        ar = a_take && !hwrite;
        rd_id = decode(haddr);
        dw = state_reg.d_act && state_reg.d_write;
        wr_id = decode(state_reg.d_addr);
        wd = hwdata[7:0];
        state_next.d_act = a_take;
        state_next.d_write = hwrite;
        state_next.d_addr = haddr;
        state_next.hrdata = 32'h0000_0000;
        if (ar)
        begin
            case (rd_id)
                SPX_REG_CTRL: state_next.hrdata[7:0] = state_reg.ctrl;
                SPX_REG_STAT: state_next.hrdata[7:0] = {state_reg.transfer_done_flag,
                    state_reg.write_collision_flag, 1'b0, state_reg.mode_fault_flag, 4'h0};
                SPX_REG_DATA: state_next.hrdata[7:0] = state_reg.rbuf;
                SPX_REG_DDR: state_next.hrdata[5:0] = state_reg.ddr;
                SPX_REG_PDAT: state_next.hrdata[5:0] = state_reg.pdat;
                default: state_next.hrdata = 32'h0000_0000;
            endcase
        end
        // A status read only arms the clear of flags it actually saw set.
        if (ar && rd_id == SPX_REG_STAT)
        begin
            state_next.transfer_done_flag_seen = state_reg.transfer_done_flag || state_reg.transfer_done_flag_seen;
            state_next.write_collision_flag_seen = state_reg.write_collision_flag || state_reg.write_collision_flag_seen;
            state_next.mode_fault_flag_seen = state_reg.mode_fault_flag || state_reg.mode_fault_flag_seen;
        end
        data_acc = (ar && rd_id == SPX_REG_DATA)
            || (dw && wr_id == SPX_REG_DATA);

        // Register writes.
        if (dw && wr_id == SPX_REG_CTRL)
        begin
            state_next.ctrl = wd;
            if (state_reg.mode_fault_flag_seen)
            begin
                state_next.mode_fault_flag = 1'b0;
                state_next.mode_fault_flag_seen = 1'b0;
            end
        end
        if (dw && wr_id == SPX_REG_DDR)
            state_next.ddr = wd[5:0];
        if (dw && wr_id == SPX_REG_PDAT)
            state_next.pdat = wd[5:0];
        if (dw && wr_id == SPX_REG_DATA)
        begin
            if (state_reg.busy)
                set_write_collision_flag = 1'b1;
            else if (!(state_reg.transfer_done_flag && !state_reg.transfer_done_flag_seen))
            begin
                state_next.shift = wd;
                state_next.out_bit = wd[7];
                if (en && master_select_bit)
                begin
                    state_next.busy = 1'b1;
                    state_next.div_cnt = 5'd0;
                    state_next.edge_cnt = 5'd0;
                end
            end
        end

        // Shift engine.
        state_next.sck_prev = sck_in;
        state_next.ss_prev = ss_in;
        if (!en)
        begin
            state_next.busy = 1'b0;
            state_next.bit_cnt = 4'd0;
            state_next.sck_lvl = clock_idle_level;
        end
        else if (master_select_bit)
        begin
            if (!state_reg.busy)
                state_next.sck_lvl = clock_idle_level;
            else if (state_reg.div_cnt == half_period(
                state_reg.ctrl[`SPX_C_RATE_HI:`SPX_C_RATE_LO]) - 5'd1)
            begin
                state_next.div_cnt = 5'd0;
                state_next.sck_lvl = !state_reg.sck_lvl;
                lead = !state_reg.edge_cnt[0];
                sample = (lead == !clock_phase_select);
                if (sample)
                begin
                    rx = {state_reg.shift[6:0], pad_in[`SPX_PIN_MISO]};
                    state_next.shift = rx;
                end
                else
                    state_next.out_bit = state_reg.shift[7];
                state_next.edge_cnt = state_reg.edge_cnt + 5'd1;
                if (state_reg.edge_cnt == `SPX_EDGES - 5'd1)
                begin
                    state_next.busy = 1'b0;
                    set_transfer_done_flag = 1'b1;
                    if (!state_reg.transfer_done_flag)
                        state_next.rbuf = state_next.shift;
                end
            end
            else
                state_next.div_cnt = state_reg.div_cnt + 5'd1;
        end
        else if (ss_in)
        begin
            // Deselect ends any slave transfer and restarts bit counting.
            state_next.busy = 1'b0;
            state_next.bit_cnt = 4'd0;
        end
        else
        begin
            if (!clock_phase_select && state_reg.ss_prev)
            begin
                state_next.busy = 1'b1;
                state_next.out_bit = state_reg.shift[7];
            end
            if (sck_in != state_reg.sck_prev)
            begin
                lead = (sck_in != clock_idle_level);
                if (clock_phase_select && lead && state_reg.bit_cnt == 4'd0)
                    state_next.busy = 1'b1;
                if (lead == !clock_phase_select)
                begin
                    rx = {state_reg.shift[6:0], pad_in[`SPX_PIN_MOSI]};
                    state_next.shift = rx;
                    state_next.bit_cnt = state_reg.bit_cnt + 4'd1;
                    if (state_reg.bit_cnt == `SPX_BITS - 4'd1)
                    begin
                        state_next.bit_cnt = 4'd0;
                        set_transfer_done_flag = 1'b1;
                        if (!state_reg.transfer_done_flag)
                            state_next.rbuf = rx;
                        if (clock_phase_select)
                            state_next.busy = 1'b0;
                    end
                end
                else
                    state_next.out_bit = state_reg.shift[7];
            end
        end

        // Mode fault overrides the control write of the same cycle.
        if (en && master_select_bit && !state_reg.ddr[`SPX_PIN_SS] && !ss_in)
        begin
            set_mode_fault_flag = 1'b1;
            state_next.ctrl[`SPX_C_EN] = 1'b0;
            state_next.ctrl[`SPX_C_MASTER_SELECT_BIT] = 1'b0;
            state_next.ddr[5:2] = 4'h0;
            state_next.busy = 1'b0;
            state_next.sck_lvl = clock_idle_level;
        end

        // Flags: a set in the clearing cycle wins.
        if (data_acc && state_reg.transfer_done_flag_seen)
        begin
            state_next.transfer_done_flag = 1'b0;
            state_next.transfer_done_flag_seen = 1'b0;
        end
        if (data_acc && state_reg.write_collision_flag_seen)
        begin
            state_next.write_collision_flag = 1'b0;
            state_next.write_collision_flag_seen = 1'b0;
        end
        if (set_transfer_done_flag)
            state_next.transfer_done_flag = 1'b1;
        if (set_write_collision_flag)
            state_next.write_collision_flag = 1'b1;
        if (set_mode_fault_flag)
            state_next.mode_fault_flag = 1'b1;
        state_next.irq = state_next.ctrl[`SPX_C_IRQEN]
            && (state_next.transfer_done_flag || state_next.mode_fault_flag);

        // Pads: general port D first, then the serial port takes over.
        // Pads follow the next state, so a pin moves with its register and
        // at the fastest rate a far-side edge is seen before the next sample.
        drv = state_next.ddr;
        val = state_next.pdat;
        if (state_next.ctrl[`SPX_C_EN])
        begin
            if (state_next.ctrl[`SPX_C_MASTER_SELECT_BIT])
            begin
                drv[`SPX_PIN_MISO] = 1'b0;
                val[`SPX_PIN_MOSI] = state_next.out_bit;
                val[`SPX_PIN_SCK] = state_next.sck_lvl;
            end
            else
            begin
                drv[`SPX_PIN_MOSI] = 1'b0;
                drv[`SPX_PIN_SCK] = 1'b0;
                drv[`SPX_PIN_MISO] = state_next.ddr[`SPX_PIN_MISO] && !ss_in;
                val[`SPX_PIN_MISO] = state_next.out_bit;
            end
        end
        for (int i = 0; i < 6; i++)
        begin
            state_next.pad.out[i] = val[i];
            state_next.pad.oe_n[i] = pad_oe_n(drv[i], val[i],
                state_next.ctrl[`SPX_C_ODS]);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= '0;
            state_reg.ctrl <= `SPX_CTRL_RESET;
            state_reg.ddr <= `SPX_DDR_RESET;
            state_reg.pdat <= `SPX_PDAT_RESET;
            state_reg.sck_prev <= 1'b0;
            state_reg.ss_prev <= 1'b1;
            state_reg.pad.oe_n <= 6'h3F;
            hready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            hready_reg <= 1'b1;
        end
    end

    assign hreadyout = hready_reg;
    assign hrdata = state_reg.hrdata;
    assign hresp = 1'b0;
    assign irq = state_reg.irq;
    assign pad_o = state_reg.pad;

endmodule : spx_port

// ==== tb/spx_port_assertions.sv ====
// Concurrent checks on the serial port pins and interrupt.
`timescale 1ns/1ps
`include "spx_cfg.svh"
module spx_port_assertions
    import spx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic irq,
    input wire logic [5:0] pad_in,
    input wire spx_pkg::spx_pad_t pad_o
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic [7:0] ctrl_sh;
    logic pend;
    logic sck_q;
    logic oe_q;
    logic tog;
    logic [4:0] gap;
    logic [4:0] half;
    logic [3:0] tcnt;
    logic sck_ctl;
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    // The shadow follows bus writes only, so a mode fault leaves it stale;
    // the clock and mosi checks therefore also require the clock pin to be driven.
    // An open-drain one is released, not dropped, so it still counts.
    assign sck_ctl = !pad_o.oe_n[`SPX_PIN_SCK] || pad_o.out[`SPX_PIN_SCK];
    assign tog = sck_ctl && !oe_q
        && (sck_q != pad_o.out[`SPX_PIN_SCK]);
    always_comb
    begin
        case (ctrl_sh[1:0])
            2'h0: half = 5'(`SPX_DIV_CODE0 >> 1);
            2'h1: half = 5'(`SPX_DIV_CODE1 >> 1);
            2'h2: half = 5'(`SPX_DIV_CODE2 >> 1);
            default: half = 5'(`SPX_DIV_CODE3 >> 1);
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_sh <= `SPX_CTRL_RESET;
            pend <= 1'h0;
            sck_q <= 1'h0;
            oe_q <= 1'h1;
            gap <= 5'h00;
            tcnt <= 4'h0;
        end
        else
        begin
            pend <= hsel && htrans[1] && hready && hwrite
                && (haddr == `SPX_ADDR_CTRL);
            if (pend)
                ctrl_sh <= hwdata[7:0];
            sck_q <= pad_o.out[`SPX_PIN_SCK];
            oe_q <= !sck_ctl;
            gap <= tog ? 5'h01 : gap + {4'h0, gap != 5'h1F};
            if (!sck_ctl)
                tcnt <= 4'h0;
            else if (tog)
                tcnt <= tcnt + 4'h1;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_last_edge;
        tog && (tcnt == 4'hF);
    endsequence
    a_irq_gated: assert property (irq |-> ctrl_sh[7] || $past(ctrl_sh[7]))
        else $error("irq raised while disabled");
    a_irq_after_frame: assert property (s_last_edge ##0 ctrl_sh[7] |-> ##[0:2] irq)
        else $error("no irq after last clock edge");
    a_irq_rise_count: assert property ($rose(irq) |-> tcnt == 4'h0
        || (tog && tcnt == 4'hF))
        else $error("irq inside an unfinished frame");
    a_sck_half_period: assert property (tog && tcnt != 4'h0 |-> gap == half)
        else $error("serial clock half period wrong");
    a_mosi_setup: assert property (tog
        && ((pad_o.out[`SPX_PIN_SCK] != ctrl_sh[3]) != ctrl_sh[2])
        |-> $stable(pad_o.out[`SPX_PIN_MOSI]))
        else $error("mosi moved at sample edge");
    a_sck_idle_level: assert property (ctrl_sh[6] && ctrl_sh[4] && !tog
        && !pad_o.oe_n[`SPX_PIN_SCK] && tcnt == 4'h0
        |-> pad_o.out[`SPX_PIN_SCK] == ctrl_sh[3])
        else $error("idle clock level wrong");
    a_open_drain: assert property (ctrl_sh[5] && $past(ctrl_sh[5])
        && $past(ctrl_sh[5], 2) |-> &(pad_o.oe_n | ~pad_o.out))
        else $error("pin drives high in open drain");
    a_miso_input: assert property (ctrl_sh[6] && ctrl_sh[4] && $past(ctrl_sh[4])
        |-> pad_o.oe_n[`SPX_PIN_MISO])
        else $error("master drives miso");
endmodule : spx_port_assertions

bind spx_port spx_port_assertions spx_port_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq), .pad_in(pad_in), .pad_o(pad_o));

// ==== tb/spx_slave_model.sv ====
// Behavioural far-side slave on the serial link.
`timescale 1ns/1ps
module spx_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel,
    input wire logic clock_idle_level,
    input wire logic clock_phase_select,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic o;
    initial
    begin
        sh = 8'h00;
        o = 1'h0;
        rx_byte = 8'h00;
    end
    always @(posedge load)
        sh = tx_byte;
    // Sample on the leading edge in phase zero, on the trailing in phase one.
    always @(sck)
        if (sel)
            if ((sck != clock_idle_level) != clock_phase_select)
                rx_byte = {rx_byte[6:0], mosi};
            else
            begin
                o = sh[7];
                sh = {sh[6:0], 1'h0};
            end
    // A deselected slave shows the inverse of its output bit, not the bit itself.
    assign miso = sel ? (clock_phase_select ? o : sh[7]) : ~(clock_phase_select ? o : sh[7]);
endmodule : spx_slave_model

// ==== tb/testbench.sv ====
// Self-checking bench: register accesses and link frames.
`timescale 1ns/1ps
`include "spx_cfg.svh"
module testbench;
    import spx_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] pad_in, ext;
    spx_pad_t pad_o;
    logic tb_ss, tb_sck, tb_mosi, psel, pload, pcpol, pcpha, pmiso;
    logic [7:0] ptx, prx, rxb, mtx;
    logic [1:0] mb;
    int failures, compares;
    localparam logic [7:0] slv_rx = 8'h3C;
    assign hready = hreadyout;
    assign ext = {tb_ss, tb_sck, tb_mosi, pmiso, 2'h3};
    assign pad_in = (pad_o.oe_n & ext) | (~pad_o.oe_n & pad_o.out);
    spx_port spx_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .irq(irq), .pad_in(pad_in),
        .pad_o(pad_o));
    spx_slave_model spx_slave_model_i (.sck(pad_in[`SPX_PIN_SCK]),
        .mosi(pad_in[`SPX_PIN_MOSI]), .sel(psel), .clock_idle_level(pcpol),
        .clock_phase_select(pcpha), .load(pload), .tx_byte(ptx), .miso(pmiso),
        .rx_byte(prx));
    initial
    begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end
    task final_report;
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            failures++;
        end
    endtask : check
    // Ready and read data are taken at the negative edge, where they hold
    // the value that the next rising edge samples.
    task wait_ready(output logic [31:0] q);
        int n;
        logic r;
        n = 0;
        r = 1'h0;
        while (!r)
        begin
            @(negedge hclk);
            r = (hreadyout === 1'h1);
            q = hrdata;
            @(posedge hclk);
            n++;
            if (n > 50)
            begin
                failures++;
                final_report();
            end
        end
    endtask : wait_ready
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_ready(rd);
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready(rd);
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask : wr
    task rchk(input logic [31:0] a, input logic [31:0] exp, input string nm);
        bus(1'h0, a, 32'h0);
        check(nm, rd, exp);
    endtask : rchk
    task set_mode(input logic [7:0] c, input logic [5:0] dd);
        wr(`SPX_ADDR_DDR, 32'h0);
        wr(`SPX_ADDR_CTRL, {24'h0, c});
        wr(`SPX_ADDR_DDR, {26'h0, dd});
    endtask : set_mode
    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'h1)
        begin
            @(posedge hclk);
            n++;
            if (n > 3000)
            begin
                failures++;
                final_report();
            end
        end
    endtask : wait_irq
    initial
    begin
        {hresetn, hwrite, psel, pload, pcpol, pcpha} = 6'h00;
        {hsel, tb_ss, tb_sck, tb_mosi} = 4'hF;
        {htrans, hsize, haddr, hwdata, ptx} = {2'h0, 3'h2, 64'h0, 8'h00};
        failures = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        rchk(`SPX_ADDR_CTRL, 32'h04, "control reset");
        rchk(`SPX_ADDR_STAT, 32'h00, "status reset");
        rchk(32'h0000_1040, 32'h00, "unmapped read");
        for (int m = 0; m < 4; m++)
        begin
            mb = m[1:0];
            mtx = {mb, 6'h2D} ^ 8'h5A;
            set_mode({2'h3, mb == 2'h3, 1'h1, mb, mb}, 6'h1C);
            {pcpol, pcpha} <= mb;
            ptx <= ~mtx;
            @(posedge hclk);
            pload <= 1'h1;
            psel <= 1'h1;
            @(posedge hclk);
            pload <= 1'h0;
            wr(`SPX_ADDR_DATA, {24'h0, mtx});
            if (m == 0)
                wr(`SPX_ADDR_DATA, 32'h55);
            wait_irq();
            check("irq done", {31'h0, irq}, 32'h1);
            if (m == 2)
                wr(`SPX_ADDR_DATA, 32'h55);
            rchk(`SPX_ADDR_STAT, m == 0 ? 32'hC0 : 32'h80, "status");
            rchk(`SPX_ADDR_DATA, {24'h0, ~mtx}, "rx byte");
            rchk(`SPX_ADDR_STAT, 32'h00, "status clear");
            repeat (300) @(posedge hclk);
            check("far rx", {24'h0, prx}, {24'h0, mtx});
            psel <= 1'h0;
        end
        set_mode(8'hD3, 6'h1C);
        tb_ss <= 1'h0;
        repeat (8) @(posedge hclk);
        check("irq fault", {31'h0, irq}, 32'h1);
        rchk(`SPX_ADDR_STAT, 32'h10, "mode fault");
        rchk(`SPX_ADDR_CTRL, 32'h83, "control fault");
        rchk(`SPX_ADDR_DDR, 32'h00, "direction fault");
        wr(`SPX_ADDR_CTRL, 32'h00);
        rchk(`SPX_ADDR_STAT, 32'h00, "fault clear");
        wr(`SPX_ADDR_DDR, 32'h3C);
        wr(`SPX_ADDR_CTRL, 32'hD0);
        repeat (8) @(posedge hclk);
        rchk(`SPX_ADDR_STAT, 32'h00, "select as output");
        tb_ss <= 1'h1;
        tb_sck <= 1'h0;
        set_mode(8'h47, 6'h14);
        wr(`SPX_ADDR_DATA, 32'hA5);
        tb_ss <= 1'h0;
        repeat (4) @(posedge hclk);
        for (int i = 7; i >= 0; i--)
        begin
            tb_sck <= 1'h1;
            tb_mosi <= slv_rx[i];
            repeat (4) @(posedge hclk);
            @(negedge hclk);
            rxb[i] = pad_in[`SPX_PIN_MISO];
            @(posedge hclk);
            tb_sck <= 1'h0;
            repeat (4) @(posedge hclk);
        end
        tb_ss <= 1'h1;
        repeat (4) @(posedge hclk);
        check("miso byte", {24'h0, rxb}, 32'hA5);
        check("sck input", {31'h0, pad_o.oe_n[`SPX_PIN_SCK]}, 32'h1);
        rchk(`SPX_ADDR_STAT, 32'h80, "slave done");
        rchk(`SPX_ADDR_DATA, {24'h0, slv_rx}, "slave rx");
        final_report();
    end
endmodule : testbench
